// *** src/cbr_field_cmp.sv ***
// Compare unit: produces one four-bit condition field
`timescale 1ns/10ps
module cbr_field_cmp (
    input  cbr_pkg::cbr_cmp_t req,
    input  logic              stickyWrap,
    output logic [3:0]        flags
);
    logic sLess;
    logic uLess;
    logic sameVal;

    assign sLess   = $signed(req.opA) < $signed(req.opB);
    assign uLess   = req.opA < req.opB;
    assign sameVal = req.opA == req.opB;

    always_comb begin
        // Field bit 0 is MSB-0, i.e. flags[3]
        case (req.kind)
            cbr_pkg::CBR_CMP_SIGNED: begin
                flags = {sLess, !sLess && !sameVal, sameVal, stickyWrap};
            end
            cbr_pkg::CBR_CMP_UNSIGNED: begin
                flags = {uLess, !uLess && !sameVal, sameVal, stickyWrap};
            end
            cbr_pkg::CBR_CMP_FLOAT: begin
                flags = {req.fpLess, req.fpGreater, req.fpEqual, req.fpUnordered};
            end
            default: begin
                flags = 4'h0;
            end
        endcase
    end
endmodule : cbr_field_cmp

// *** src/cbr_pkg.sv ***
// Package: constants and carrier types for the condition and branch registers
package cbr_pkg;
    // Register indices on the move-to/move-from special register port
    localparam logic [9:0] EXC_IDX      = 10'h001;
    localparam logic [9:0] LINK_IDX     = 10'h008;
    localparam logic [9:0] COUNT_IDX    = 10'h009;
    localparam logic [9:0] COND_IDX     = 10'h3ff;

    // Integer exception register fields, LSB-numbered (MSB-0 bit n is 31-n)
    localparam int EXC_STICKY_POS       = 31;
    localparam int EXC_WRAP_POS         = 30;
    localparam int EXC_SPILL_POS        = 29;
    localparam int EXC_KEEP_HI          = 15;
    localparam int EXC_KEEP_LO          = 8;
    localparam int EXC_BYTES_HI         = 6;
    localparam logic [31:0] EXC_WMASK   = 32'he000ff7f;

    // Reset values
    localparam logic [31:0] EXC_RST     = 32'h00000000;
    localparam logic [31:0] LINK_RST    = 32'h00000000;
    localparam logic [31:0] COUNT_RST   = 32'h00000000;
    localparam logic [31:0] COND_RST    = 32'h00000000;

    // Field of the condition flags register that holds the floating-point summary
    localparam logic [2:0] FP_SUMMARY_FIELD = 3'h1;

    typedef enum logic [1:0] {
        CBR_CMP_SIGNED   = 2'h0,
        CBR_CMP_UNSIGNED = 2'h1,
        CBR_CMP_FLOAT    = 2'h3
    } cbr_cmp_kind_t;

    // Compare request
    typedef struct packed {
        logic          valid;
        cbr_cmp_kind_t kind;
        logic [2:0]    field;
        logic [31:0]   opA;
        logic [31:0]   opB;
        logic          fpLess;
        logic          fpGreater;
        logic          fpEqual;
        logic          fpUnordered;
    } cbr_cmp_t;

    // Arithmetic completion report, flags from the whole result
    typedef struct packed {
        logic valid;
        logic wrapEnable;
        logic carryOp;
        logic carry0;
        logic carry1;
        logic shiftAlg;
        logic srcNegative;
        logic lostOnes;
    } cbr_arith_t;

    // Branch request
    typedef struct packed {
        logic        valid;
        logic        link;
        logic        decCount;
        logic [31:0] nextPc;
    } cbr_branch_t;

    // Special register move
    typedef struct packed {
        logic        write;
        logic [9:0]  idx;
        logic [31:0] data;
    } cbr_move_t;
endpackage : cbr_pkg

// *** src/cbr_regs.sv ***
// Condition flags, integer exception, return link and loop count registers
`timescale 1ns/10ps
module cbr_regs (
    input  logic                 clk,
    input  logic                 reset,
    input  cbr_pkg::cbr_cmp_t    cmpReq,
    input  cbr_pkg::cbr_arith_t  arithReq,
    input  cbr_pkg::cbr_branch_t branchReq,
    input  cbr_pkg::cbr_move_t   moveReq,
    input  logic                 fpRecord,
    input  logic [3:0]           fpStatusTop,
    output logic [31:0]          condFlags,
    output logic [31:0]          intException,
    output logic [31:0]          linkTarget,
    output logic [31:0]          countTarget,
    output logic [31:0]          linkValue,
    output logic [31:0]          countValue,
    output logic [6:0]           stringBytes,
    output logic [31:0]          moveData
);
    // =========================================
    // Decoded requests
    logic        moveCond;
    logic        moveExc;
    logic        moveLink;
    logic        moveCount;
    logic        branchLink;
    logic        branchCount;
    logic        wrapNow;

    // =========================================
    // Register storage
    logic [31:0]      cond_q;
    wire logic [31:0] cond_d;
    logic             sticky_q;
    logic             sticky_d;
    logic             wrap_q;
    logic             wrap_d;
    logic             spill_q;
    logic             spill_d;
    logic [7:0]       keep_q;
    logic [7:0]       keep_d;
    logic [6:0]       bytes_q;
    logic [6:0]       bytes_d;
    logic [31:0]      excValue;
    logic [31:0]      link_q;
    logic [31:0]      link_d;
    logic [31:0]      count_q;
    logic [31:0]      count_d;
    logic [31:0]      moveData_q;
    logic [31:0]      moveData_d;
    logic [3:0]       cmpFlags;

    // =========================================
    // Request decode
    always_comb begin
        moveCond  = moveReq.write && (moveReq.idx == cbr_pkg::COND_IDX);
        moveExc   = moveReq.write && (moveReq.idx == cbr_pkg::EXC_IDX);
        moveLink  = moveReq.write && (moveReq.idx == cbr_pkg::LINK_IDX);
        moveCount = moveReq.write && (moveReq.idx == cbr_pkg::COUNT_IDX);
    end

    always_comb begin
        branchLink  = branchReq.valid && branchReq.link;
        branchCount = branchReq.valid && branchReq.decCount;
    end

    // =========================================
    // Compare unit
    cbr_field_cmp u_cmp (
        .req        (cmpReq),
        .stickyWrap (sticky_q),
        .flags      (cmpFlags)
    );

    // =========================================
    // Condition flags register, one slice per field
    genvar fieldIdx;
    generate
        for (fieldIdx = 0; fieldIdx < 8; fieldIdx++) begin : g_field
            logic [3:0] field_d;

            // Compare beats summary load beats move
            always_comb begin
                field_d = cond_q[(7 - fieldIdx) * 4 +: 4];
                if (moveCond) begin
                    field_d = moveReq.data[(7 - fieldIdx) * 4 +: 4];
                end
                if (fpRecord && (fieldIdx == int'(cbr_pkg::FP_SUMMARY_FIELD))) begin
                    field_d = fpStatusTop;
                end
                if (cmpReq.valid && (cmpReq.field == 3'(fieldIdx))) begin
                    field_d = cmpFlags;
                end
            end

            assign cond_d[(7 - fieldIdx) * 4 +: 4] = field_d;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            cond_q <= cbr_pkg::COND_RST;
        end else begin
            cond_q <= cond_d;
        end
    end

    // =========================================
    // Integer exception register
    always_comb begin
        wrapNow = arithReq.carry0 ^ arithReq.carry1;
    end

    // Sticky bit: arithmetic set wins over a clearing move
    always_comb begin
        sticky_d = sticky_q;
        if (moveExc) begin
            sticky_d = moveReq.data[cbr_pkg::EXC_STICKY_POS];
        end
        if (arithReq.valid && arithReq.wrapEnable && wrapNow) begin
            sticky_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sticky_q <= cbr_pkg::EXC_RST[cbr_pkg::EXC_STICKY_POS];
        end else begin
            sticky_q <= sticky_d;
        end
    end

    // Wrap bit from whole-result carries
    always_comb begin
        wrap_d = wrap_q;
        if (moveExc) begin
            wrap_d = moveReq.data[cbr_pkg::EXC_WRAP_POS];
        end
        if (arithReq.valid && arithReq.wrapEnable) begin
            wrap_d = wrapNow;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrap_q <= cbr_pkg::EXC_RST[cbr_pkg::EXC_WRAP_POS];
        end else begin
            wrap_q <= wrap_d;
        end
    end

    // Spill bit from carrying ops and algebraic shifts
    always_comb begin
        spill_d = spill_q;
        if (moveExc) begin
            spill_d = moveReq.data[cbr_pkg::EXC_SPILL_POS];
        end
        if (arithReq.valid && arithReq.carryOp) begin
            spill_d = arithReq.carry0;
        end else if (arithReq.valid && arithReq.shiftAlg) begin
            spill_d = arithReq.srcNegative && arithReq.lostOnes;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            spill_q <= cbr_pkg::EXC_RST[cbr_pkg::EXC_SPILL_POS];
        end else begin
            spill_q <= spill_d;
        end
    end

    // Software-owned bits, no hardware update
    always_comb begin
        keep_d = keep_q;
        if (moveExc) begin
            keep_d = moveReq.data[cbr_pkg::EXC_KEEP_HI:cbr_pkg::EXC_KEEP_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            keep_q <= cbr_pkg::EXC_RST[cbr_pkg::EXC_KEEP_HI:cbr_pkg::EXC_KEEP_LO];
        end else begin
            keep_q <= keep_d;
        end
    end

    // Byte count for string moves
    always_comb begin
        bytes_d = bytes_q;
        if (moveExc) begin
            bytes_d = moveReq.data[cbr_pkg::EXC_BYTES_HI:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bytes_q <= cbr_pkg::EXC_RST[cbr_pkg::EXC_BYTES_HI:0];
        end else begin
            bytes_q <= bytes_d;
        end
    end

    // Unused positions read as zero
    always_comb begin
        excValue = {sticky_q, wrap_q, spill_q, 13'h0000, keep_q, 1'h0, bytes_q};
    end

    // =========================================
    // Return link register
    // Branch link wins over a same-cycle move
    always_comb begin
        link_d = link_q;
        if (branchLink) begin
            link_d = branchReq.nextPc;
        end else if (moveLink) begin
            link_d = moveReq.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            link_q <= cbr_pkg::LINK_RST;
        end else begin
            link_q <= link_d;
        end
    end

    // =========================================
    // Loop count register
    // Decrement wins; zero wraps to all ones
    always_comb begin
        count_d = count_q;
        if (branchCount) begin
            count_d = count_q - 32'h00000001;
        end else if (moveCount) begin
            count_d = moveReq.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= cbr_pkg::COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // =========================================
    // Read port
    // Registered read, one cycle after the index
    always_comb begin
        case (moveReq.idx)
            cbr_pkg::EXC_IDX:   moveData_d = excValue;
            cbr_pkg::LINK_IDX:  moveData_d = link_q;
            cbr_pkg::COUNT_IDX: moveData_d = count_q;
            cbr_pkg::COND_IDX:  moveData_d = cond_q;
            default:            moveData_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            moveData_q <= 32'h00000000;
        end else begin
            moveData_q <= moveData_d;
        end
    end

    // =========================================
    // Outputs
    assign condFlags    = cond_q;
    assign intException = excValue;
    assign linkValue    = link_q;
    assign countValue   = count_q;
    assign linkTarget   = {link_q[31:2], 2'h0};
    assign countTarget  = {count_q[31:2], 2'h0};
    assign stringBytes  = bytes_q;
    assign moveData     = moveData_q;
endmodule : cbr_regs

// *** tb/cbr_exec_model.sv ***
// Execution and branch unit model issuing one-cycle requests
`timescale 1ns/10ps
module cbr_exec_model (
    input  logic                 clk,
    output cbr_pkg::cbr_cmp_t    cmpReq,
    output cbr_pkg::cbr_arith_t  arithReq,
    output cbr_pkg::cbr_branch_t branchReq,
    output cbr_pkg::cbr_move_t   moveReq,
    output logic                 fpRecord,
    output logic [3:0]           fpStatusTop
);
    initial begin
        cmpReq = '0;
        arithReq = '0;
        branchReq = '0;
        moveReq = '0;
        fpRecord = 1'b0;
        fpStatusTop = 4'h0;
    end
    task cmp(input cbr_pkg::cbr_cmp_t v);
        @(posedge clk) cmpReq <= v;
        @(posedge clk) cmpReq <= '0;
    endtask : cmp
    task ar(input cbr_pkg::cbr_arith_t v);
        @(posedge clk) arithReq <= v;
        @(posedge clk) arithReq <= '0;
    endtask : ar
    task br(input cbr_pkg::cbr_branch_t v);
        @(posedge clk) branchReq <= v;
        @(posedge clk) branchReq <= '0;
    endtask : br
    task mv(input cbr_pkg::cbr_move_t v);
        @(posedge clk) moveReq <= v;
        @(posedge clk) moveReq <= '0;
    endtask : mv
    task fp(input logic [3:0] s);
        @(posedge clk) {fpRecord, fpStatusTop} <= {1'b1, s};
        @(posedge clk) {fpRecord, fpStatusTop} <= {1'b0, ~s};
    endtask : fp
endmodule : cbr_exec_model

// *** tb/cbr_regs_chk_sva.sv ***
// Checker for the condition and branch registers
`timescale 1ns/10ps
module cbr_regs_chk (
    input logic                 clk,
    input logic                 reset,
    input cbr_pkg::cbr_cmp_t    cmpReq,
    input cbr_pkg::cbr_arith_t  arithReq,
    input cbr_pkg::cbr_branch_t branchReq,
    input cbr_pkg::cbr_move_t   moveReq,
    input logic                 fpRecord,
    input logic [3:0]           fpStatusTop,
    input logic [31:0]          condFlags,
    input logic [31:0]          intException,
    input logic [31:0]          linkTarget,
    input logic [31:0]          countTarget,
    input logic [31:0]          linkValue,
    input logic [31:0]          countValue,
    input logic [6:0]           stringBytes,
    input logic [31:0]          moveData
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_link_addr: assert property (linkTarget == {linkValue[31:2], 2'h0})
        else $error("link target wrong");
    chk_count_addr: assert property (countTarget == {countValue[31:2], 2'h0})
        else $error("count target wrong");
    chk_byte_count: assert property (stringBytes == intException[6:0])
        else $error("byte count wrong");
    chk_link_store: assert property (branchReq.valid && branchReq.link |=> linkValue == $past(branchReq.nextPc))
        else $error("link not stored");
    chk_count_step: assert property (branchReq.valid && branchReq.decCount |=> countValue == $past(countValue) - 32'h1)
        else $error("count not decremented");
    chk_sticky_hold: assert property (
        intException[31] && !(moveReq.write && moveReq.idx == cbr_pkg::EXC_IDX) |=> intException[31])
        else $error("sticky overflow lost");
    chk_cmp_less: assert property (
        cmpReq.valid && cmpReq.kind == cbr_pkg::CBR_CMP_SIGNED && $signed(cmpReq.opA) < $signed(cmpReq.opB)
        |=> condFlags[31 - 4 * $past(cmpReq.field)])
        else $error("less bit not set");
    chk_cmp_equal: assert property (
        cmpReq.valid && (cmpReq.kind == cbr_pkg::CBR_CMP_SIGNED || cmpReq.kind == cbr_pkg::CBR_CMP_UNSIGNED)
        && cmpReq.opA == cmpReq.opB |=> condFlags[29 - 4 * $past(cmpReq.field)])
        else $error("equal bit not set");
    chk_fp_summary: assert property (
        fpRecord && !(cmpReq.valid && cmpReq.field == cbr_pkg::FP_SUMMARY_FIELD)
        |=> condFlags[27:24] == $past(fpStatusTop))
        else $error("summary field wrong");
    chk_wrap_flag: assert property (
        arithReq.valid && arithReq.wrapEnable
        |=> intException[30] == ($past(arithReq.carry0) ^ $past(arithReq.carry1)))
        else $error("wrap bit wrong");
    chk_spill_flag: assert property (
        arithReq.valid && arithReq.carryOp |=> intException[29] == $past(arithReq.carry0))
        else $error("spill bit wrong");
    cover property (cmpReq.valid);
    cover property (branchReq.valid && branchReq.decCount && countValue == 32'h0);
    cover property (moveReq.write);
    cover property (fpRecord);
endmodule : cbr_regs_chk
bind cbr_regs cbr_regs_chk u_chk (
    .clk          (clk),
    .reset        (reset),
    .cmpReq       (cmpReq),
    .arithReq     (arithReq),
    .branchReq    (branchReq),
    .moveReq      (moveReq),
    .fpRecord     (fpRecord),
    .fpStatusTop  (fpStatusTop),
    .condFlags    (condFlags),
    .intException (intException),
    .linkTarget   (linkTarget),
    .countTarget  (countTarget),
    .linkValue    (linkValue),
    .countValue   (countValue),
    .stringBytes  (stringBytes),
    .moveData     (moveData)
);

// *** tb/cbr_regs_test.sv ***
// Self-checking test of the condition and branch registers
`timescale 1ns/10ps
module cbr_regs_test;
    logic                 clk;
    logic                 reset;
    cbr_pkg::cbr_cmp_t    cmpReq;
    cbr_pkg::cbr_arith_t  arithReq;
    cbr_pkg::cbr_branch_t branchReq;
    cbr_pkg::cbr_move_t   moveReq;
    logic                 fpRecord;
    logic [3:0]           fpStatusTop;
    logic [31:0]          condFlags, intException, linkTarget, countTarget, linkValue, countValue, moveData;
    logic [6:0]           stringBytes;
    int                   errors;
    int                   num_checks;
    cbr_exec_model u_exec (
        .clk         (clk),
        .cmpReq      (cmpReq),
        .arithReq    (arithReq),
        .branchReq   (branchReq),
        .moveReq     (moveReq),
        .fpRecord    (fpRecord),
        .fpStatusTop (fpStatusTop)
    );
    cbr_regs dut (
        .clk          (clk),
        .reset        (reset),
        .cmpReq       (cmpReq),
        .arithReq     (arithReq),
        .branchReq    (branchReq),
        .moveReq      (moveReq),
        .fpRecord     (fpRecord),
        .fpStatusTop  (fpStatusTop),
        .condFlags    (condFlags),
        .intException (intException),
        .linkTarget   (linkTarget),
        .countTarget  (countTarget),
        .linkValue    (linkValue),
        .countValue   (countValue),
        .stringBytes  (stringBytes),
        .moveData     (moveData)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [9:0] idx, input logic [31:0] exp);
        u_exec.mv({1'b0, idx, 32'h0});
        #1 chk(moveData, exp);
    endtask : rd
    task results;
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    initial begin
        repeat (500) @(posedge clk);
        errors++;
        results();
    end
    initial begin
        errors = 0;
        num_checks = 0;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(cbr_pkg::COND_IDX, 32'h0);
        u_exec.mv({1'b1, 10'h005, 32'hffffffff});
        rd(10'h005, 32'h0);
        u_exec.mv({1'b1, cbr_pkg::EXC_IDX, 32'hffffffff});
        rd(cbr_pkg::EXC_IDX, 32'he000ff7f);
        u_exec.mv({1'b1, cbr_pkg::EXC_IDX, 32'h0});
        u_exec.ar(8'hd0);
        #1 chk(intException, 32'hc0000000);
        u_exec.ar(8'hc0);
        #1 chk(intException, 32'h80000000);
        u_exec.ar(8'hb0);
        #1 chk(intException, 32'ha0000000);
        u_exec.ar(8'h86);
        #1 chk(intException, 32'h80000000);
        u_exec.ar(8'h87);
        #1 chk(intException, 32'ha0000000);
        u_exec.cmp({1'b1, 2'h0, 3'h2, 32'hffffffff, 32'h1, 4'h0});
        #1 chk(condFlags, 32'h00900000);
        u_exec.cmp({1'b1, 2'h1, 3'h3, 32'hffffffff, 32'h1, 4'h0});
        #1 chk(condFlags, 32'h00950000);
        u_exec.cmp({1'b1, 2'h0, 3'h0, 32'h5, 32'h5, 4'h0});
        #1 chk(condFlags, 32'h30950000);
        u_exec.cmp({1'b1, 2'h3, 3'h7, 32'h0, 32'h0, 4'h1});
        #1 chk(condFlags, 32'h30950001);
        u_exec.fp(4'ha);
        #1 chk(condFlags, 32'h3a950001);
        u_exec.mv({1'b1, cbr_pkg::EXC_IDX, 32'h0000a555});
        #1 chk({25'h0, stringBytes}, 32'h55);
        u_exec.br({1'b1, 1'b1, 1'b1, 32'h1237});
        #1 chk(linkTarget, 32'h1234);
        rd(cbr_pkg::LINK_IDX, 32'h1237);
        chk(countTarget, 32'hfffffffc);
        u_exec.br({1'b1, 1'b0, 1'b1, 32'h0});
        #1 chk(countValue, 32'hfffffffe);
        chk(linkValue, 32'h1237);
        results();
    end
endmodule : cbr_regs_test
